// file: inc/rxcs_pkg.sv
// Shared constants and types of the receive-command sequencer
package rxcs_pkg;
  // Command framing
  localparam logic [1:0] CMD_HEADER = 2'h2;
  localparam logic [3:0] BIT_FREQ = 4'h4;
  localparam logic [3:0] BIT_FULL = 4'h8;
  localparam logic [3:0] BIT_ACT = 4'h9;
  // Operating states of the device
  localparam logic [1:0] DEV_STATE_OFF = 2'h0;
  localparam logic [1:0] DEV_STATE_RX = 2'h2;
  // Sub-commands
  localparam logic [1:0] SUB_RESUME = 2'h0;
  localparam logic [1:0] SUB_WAKEUP = 2'h1;
  localparam logic [1:0] SUB_PREAMBLE = 2'h2;
  localparam logic [1:0] SUB_DATA = 2'h3;
  // Gain selections
  localparam logic [1:0] GAIN_KEEP = 2'h0;
  localparam logic [1:0] GAIN_AUTO = 2'h1;
  localparam logic [1:0] GAIN_LOW = 2'h2;
  localparam logic [1:0] GAIN_HIGH = 2'h3;
  // Follow-up actions
  localparam logic [1:0] FU_STOP = 2'h0;
  localparam logic [1:0] FU_DATA = 2'h1;
  localparam logic [1:0] FU_PREAMBLE_THEN_DATA_CMD = 2'h2;
  localparam logic [1:0] FU_POWERDOWN = 2'h3;
  // Dynamic configuration sets
  localparam logic [1:0] DYN_WAKEUP = 2'h0;
  localparam logic [1:0] DYN_PREAMBLE = 2'h1;
  localparam logic [1:0] DYN_DATA = 2'h2;
  // Clock-line output delay in reference periods: field plus one
  localparam logic [4:0] DELAY_ADD = 5'h01;
  localparam logic [4:0] DELAY_MAX = 5'h0f;

  typedef struct packed {
    logic [1:0] subcmd;
    logic [1:0] gain_sel;
  } rxcs_cmd_s;

  typedef struct packed {
    logic sclk_o;
    logic sclk_oe_n;
    logic sdio_o;
    logic sdio_oe_n;
  } rxcs_pins_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAKEUP = 4'h2,
    ST_PREAMBLE = 4'h4,
    ST_DATA = 4'h8
  } rxcs_state_e;
endpackage : rxcs_pkg

// file: hw/rxcs_top.sv
// Receive-command sequencer: serial command decode, receive phases, output switching
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Found preamble moves seamlessly to data, data config set, detection restarted.
// - Preamble timeout follows the preamble follow-up setting.
// - Detection status is held when preamble detection finds the preamble or times out.
// - Digitised output is static in preamble search, clocks data after.
// - Transparent output always drives chip clock and deglitched slicer data.
// - Direct data skips preamble, uses data set, initialises slicer.
// - Data reception never ends by itself; host restarts or powers off.
// - Gain flags: keep, auto for wakeup only, force low, force high.
// - Auto gain starts high, drops to low above the high-gain threshold.
// - Wakeup timer ignores automatic gain switching.
// - After fourth bit: receive state, frequency applied, oscillator started.
// - Calibration and lock on first command or changed frequency.
// - After eighth bit flags are latched, phase machine unchanged.
// - Next rising edge starts the command; resume leaves phase alone.
// - Data line switched at once; clock line after a counted delay.
// - Clock-line delay is field plus one reference periods, field up to 15.
// - Digitised clock high in search phases; data low in wakeup search.
// - Dynamic configuration set follows the receive phase automatically.
// - Slicer initialisation offers only two alternative sets.
// - Follow-up chosen by timer or host start, success or failure.
// - End of wakeup or preamble search raises an event.
// - Host may interrupt output; resume re-enables; detection keeps running.
// - Command byte: 1, 0, frequency, sub-command, gain pairs in order.
// - Sub-command: 00 resume, 01 wakeup, 10 preamble-data, 11 data.
module rxcs_top #(
  parameter int STATUS_W = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic link_en_n,
  input wire logic link_din,
  output rxcs_pkg::rxcs_pins_s pins,
  input wire logic transparent_mode,
  input wire logic [4:0] clock_line_output_delay,
  input wire logic [1:0] after_wakeup_action_ts,
  input wire logic [1:0] after_wakeup_action_tf,
  input wire logic [1:0] after_wakeup_action_cs,
  input wire logic [1:0] after_wakeup_action_cf,
  input wire logic after_preamble_action_tf,
  input wire logic after_preamble_action_cf,
  input wire logic [7:0] high_gain_rssi_threshold,
  input wire logic [7:0] rssi_level,
  input wire logic poll_timer_start,
  input wire logic wakeup_found,
  input wire logic wakeup_not_found,
  input wire logic preamble_found,
  input wire logic preamble_timeout,
  input wire logic [STATUS_W-1:0] detect_status,
  input wire logic chip_clk,
  input wire logic slicer_out,
  input wire logic data_clk,
  input wire logic data_bit,
  output logic [1:0] device_operating_state,
  output logic osc_start,
  output logic vco_cal_start,
  output rxcs_pkg::rxcs_state_e phase,
  output logic [1:0] dyn_config_sel,
  output logic detect_restart,
  output logic slicer_init,
  output logic slicer_init_choice,
  output logic [STATUS_W-1:0] held_status,
  output logic gain_high_sel,
  output logic wakeup_timer_run,
  output logic phase_end_event,
  output logic power_down_req
);

  // Link domain
  logic frame_clr;
  logic [3:0] bitcnt_r;
  logic [7:0] shift_r;
  logic cmd_ok_r;
  logic [1:0] freq_link_r;
  rxcs_pkg::rxcs_cmd_s cmd_link_r;
  logic freq_tgl_r;
  logic act_tgl_r;

  // A frame ends when the enable rises; no link edge is needed to clear it
  assign frame_clr = rst | link_en_n;

  // Bits arrive first-bit-first on the rising edge
  always_ff @(posedge link_clk or posedge frame_clr) begin
    if (frame_clr) begin
      bitcnt_r <= 4'h0;
      shift_r <= 8'h00;
    end else if (bitcnt_r != rxcs_pkg::BIT_ACT) begin
      bitcnt_r <= bitcnt_r + 4'h1;
      shift_r <= {shift_r[6:0], link_din};
    end
  end

  // Flags valid only inside the frame that carried them
  always_ff @(negedge link_clk or posedge frame_clr) begin
    if (frame_clr) begin
      cmd_ok_r <= 1'b0;
    end else if (bitcnt_r == rxcs_pkg::BIT_FULL) begin
      cmd_ok_r <= (shift_r[7:6] == rxcs_pkg::CMD_HEADER);
    end
  end

  // Frequency after bit four, flags after bit eight; these hold across frames
  always_ff @(negedge link_clk or posedge rst) begin
    if (rst) begin
      freq_link_r <= 2'h0;
      cmd_link_r <= '0;
      freq_tgl_r <= 1'b0;
    end else begin
      if (bitcnt_r == rxcs_pkg::BIT_FREQ && shift_r[3:2] == rxcs_pkg::CMD_HEADER) begin
        freq_link_r <= shift_r[1:0];
        freq_tgl_r <= ~freq_tgl_r;
      end
      if (bitcnt_r == rxcs_pkg::BIT_FULL && shift_r[7:6] == rxcs_pkg::CMD_HEADER) begin
        cmd_link_r <= {shift_r[3:2], shift_r[1:0]};
      end
    end
  end

  // Activation on the rising edge after the full byte
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      act_tgl_r <= 1'b0;
    end else if (bitcnt_r == rxcs_pkg::BIT_FULL && cmd_ok_r && !link_en_n) begin
      act_tgl_r <= ~act_tgl_r;
    end
  end

  // Crossing into the core domain
  logic [2:0] async_in;
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] prev_r;
  logic freq_evt;
  logic act_evt;
  logic en_fall;

  assign async_in = {link_en_n, act_tgl_r, freq_tgl_r};

  // Two flops per bit; the words behind the toggles are stable by the time they are read
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        sync1_r[i] <= (i == 2);
        sync2_r[i] <= (i == 2);
        prev_r[i] <= (i == 2);
      end else begin
        sync1_r[i] <= async_in[i];
        sync2_r[i] <= sync1_r[i];
        prev_r[i] <= sync2_r[i];
      end
    end
  end

  assign freq_evt = sync2_r[0] ^ prev_r[0];
  assign act_evt = sync2_r[1] ^ prev_r[1];
  assign en_fall = prev_r[2] & ~sync2_r[2];

  // Receive phase machine
  rxcs_pkg::rxcs_state_e st_r;
  rxcs_pkg::rxcs_state_e st_nxt;
  logic by_timer_r;
  logic pdown_nxt;
  logic init_nxt;
  logic restart_nxt;
  logic [1:0] wu_action;
  rxcs_pkg::rxcs_cmd_s cmd;

  assign cmd = cmd_link_r;

  // Follow-up action to next phase; power-down and stop both park the machine
  function automatic rxcs_pkg::rxcs_state_e fu_target(input logic [1:0] act);
    case (act)
      rxcs_pkg::FU_DATA: fu_target = rxcs_pkg::ST_DATA;
      rxcs_pkg::FU_PREAMBLE_THEN_DATA_CMD: fu_target = rxcs_pkg::ST_PREAMBLE;
      default: fu_target = rxcs_pkg::ST_IDLE;
    endcase
  endfunction : fu_target

  always_comb begin
    wu_action = wakeup_found ? (by_timer_r ? after_wakeup_action_ts : after_wakeup_action_cs)
                             : (by_timer_r ? after_wakeup_action_tf : after_wakeup_action_cf);
  end

  // Commands take priority over phase ends: every start command restarts
  always_comb begin
    st_nxt = st_r;
    pdown_nxt = 1'b0;
    init_nxt = 1'b0;
    restart_nxt = 1'b0;
    if (act_evt && cmd.subcmd != rxcs_pkg::SUB_RESUME) begin
      init_nxt = 1'b1;
      restart_nxt = 1'b1;
      case (cmd.subcmd)
        rxcs_pkg::SUB_WAKEUP: st_nxt = rxcs_pkg::ST_WAKEUP;
        rxcs_pkg::SUB_PREAMBLE: st_nxt = rxcs_pkg::ST_PREAMBLE;
        default: st_nxt = rxcs_pkg::ST_DATA;
      endcase
    end else begin
      case (st_r)
        rxcs_pkg::ST_IDLE: begin
          if (poll_timer_start) begin
            st_nxt = rxcs_pkg::ST_WAKEUP;
            init_nxt = 1'b1;
            restart_nxt = 1'b1;
          end
        end
        rxcs_pkg::ST_WAKEUP: begin
          if (wakeup_found || wakeup_not_found) begin
            st_nxt = fu_target(wu_action);
            pdown_nxt = !wakeup_found && wu_action == rxcs_pkg::FU_POWERDOWN;
            init_nxt = fu_target(wu_action) != rxcs_pkg::ST_IDLE;
            restart_nxt = init_nxt;
          end
        end
        rxcs_pkg::ST_PREAMBLE: begin
          if (preamble_found) begin
            st_nxt = rxcs_pkg::ST_DATA;
            restart_nxt = 1'b1;
          end else if (preamble_timeout) begin
            st_nxt = rxcs_pkg::ST_IDLE;
            pdown_nxt = by_timer_r ? after_preamble_action_tf : after_preamble_action_cf;
          end
        end
        rxcs_pkg::ST_DATA: st_nxt = rxcs_pkg::ST_DATA;
        default: st_nxt = rxcs_pkg::ST_IDLE;
      endcase
    end
  end

  // Phase register and its pulses
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= rxcs_pkg::ST_IDLE;
      by_timer_r <= 1'b0;
      power_down_req <= 1'b0;
      slicer_init <= 1'b0;
      detect_restart <= 1'b0;
      phase_end_event <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (act_evt && cmd.subcmd != rxcs_pkg::SUB_RESUME) begin
        by_timer_r <= 1'b0;
      end else if (st_r == rxcs_pkg::ST_IDLE && poll_timer_start) begin
        by_timer_r <= 1'b1;
      end
      power_down_req <= pdown_nxt;
      slicer_init <= init_nxt;
      detect_restart <= restart_nxt;
      phase_end_event <= (st_r == rxcs_pkg::ST_WAKEUP && (wakeup_found || wakeup_not_found))
                      || (st_r == rxcs_pkg::ST_PREAMBLE && (preamble_found || preamble_timeout));
    end
  end

  // Detection status snapshot at the end of a search phase
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      held_status <= '0;
    end else if ((st_r == rxcs_pkg::ST_PREAMBLE && (preamble_found || preamble_timeout))
              || (st_r == rxcs_pkg::ST_WAKEUP && (wakeup_found || wakeup_not_found))) begin
      held_status <= detect_status;
    end
  end

  assign phase = st_r;
  // The search timer only looks at the phase, so a gain switch cannot disturb it
  assign wakeup_timer_run = (st_r == rxcs_pkg::ST_WAKEUP);

  // Dynamic configuration follows the phase; slicer sets are two only
  always_comb begin
    case (st_r)
      rxcs_pkg::ST_PREAMBLE: dyn_config_sel = rxcs_pkg::DYN_PREAMBLE;
      rxcs_pkg::ST_DATA: dyn_config_sel = rxcs_pkg::DYN_DATA;
      default: dyn_config_sel = rxcs_pkg::DYN_WAKEUP;
    endcase
  end
  assign slicer_init_choice = (st_r != rxcs_pkg::ST_WAKEUP);

  // Frequency, power and calibration
  logic first_done_r;
  logic [1:0] last_freq_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      device_operating_state <= rxcs_pkg::DEV_STATE_OFF;
      osc_start <= 1'b0;
      vco_cal_start <= 1'b0;
      first_done_r <= 1'b0;
      last_freq_r <= 2'h0;
    end else begin
      osc_start <= freq_evt;
      vco_cal_start <= freq_evt && (!first_done_r || freq_link_r != last_freq_r);
      if (freq_evt) begin
        device_operating_state <= rxcs_pkg::DEV_STATE_RX;
        first_done_r <= 1'b1;
        last_freq_r <= freq_link_r;
      end else if (pdown_nxt) begin
        device_operating_state <= rxcs_pkg::DEV_STATE_OFF;
      end
    end
  end

  // Gain selection
  logic auto_gain_r;

  // Automatic switching only ever lowers the gain, and only while searching
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gain_high_sel <= 1'b1;
      auto_gain_r <= 1'b0;
    end else if (act_evt && cmd.subcmd != rxcs_pkg::SUB_RESUME) begin
      auto_gain_r <= cmd.gain_sel == rxcs_pkg::GAIN_AUTO && cmd.subcmd == rxcs_pkg::SUB_WAKEUP;
      case (cmd.gain_sel)
        rxcs_pkg::GAIN_LOW: gain_high_sel <= 1'b0;
        rxcs_pkg::GAIN_HIGH: gain_high_sel <= 1'b1;
        rxcs_pkg::GAIN_AUTO: begin
          if (cmd.subcmd == rxcs_pkg::SUB_WAKEUP) begin
            gain_high_sel <= 1'b1;
          end
        end
        default: gain_high_sel <= gain_high_sel;
      endcase
    end else if (st_r != rxcs_pkg::ST_WAKEUP) begin
      auto_gain_r <= 1'b0;
    end else if (auto_gain_r && rssi_level > high_gain_rssi_threshold) begin
      gain_high_sel <= 1'b0;
    end
  end

  // Output switching onto the serial lines
  logic out_en_r;
  logic [4:0] dly_r;
  logic [4:0] dly_cap;

  assign dly_cap = (clock_line_output_delay > rxcs_pkg::DELAY_MAX) ? rxcs_pkg::DELAY_MAX
                                                                     : clock_line_output_delay;

  // A new host access takes the lines back; resume hands them out again
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_en_r <= 1'b0;
      dly_r <= 5'h00;
    end else if (act_evt) begin
      out_en_r <= 1'b1;
      dly_r <= dly_cap + rxcs_pkg::DELAY_ADD;
    end else begin
      if (en_fall) begin
        out_en_r <= 1'b0;
      end
      if (dly_r != 5'h00) begin
        dly_r <= dly_r - 5'h01;
      end
    end
  end

  // Registered line values; the digitised form hides search activity
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pins <= '{sclk_o: 1'b1, sclk_oe_n: 1'b1, sdio_o: 1'b0, sdio_oe_n: 1'b1};
    end else begin
      pins.sdio_oe_n <= ~out_en_r;
      pins.sclk_oe_n <= ~(out_en_r && dly_r == 5'h00);
      if (transparent_mode) begin
        pins.sclk_o <= chip_clk;
        pins.sdio_o <= slicer_out;
      end else if (st_r == rxcs_pkg::ST_DATA) begin
        pins.sclk_o <= data_clk;
        pins.sdio_o <= data_bit;
      end else begin
        pins.sclk_o <= 1'b1;
        pins.sdio_o <= (st_r == rxcs_pkg::ST_PREAMBLE);
      end
    end
  end

  // Checks
  logic [5:0] since_act_r;
  logic [4:0] dly_at_act_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      since_act_r <= 6'h00;
      dly_at_act_r <= 5'h00;
    end else if (act_evt) begin
      since_act_r <= 6'h01;
      dly_at_act_r <= dly_cap;
    end else if (since_act_r != 6'h3f) begin
      since_act_r <= since_act_r + 6'h01;
    end
  end

  property p_pre_to_data;
    @(posedge core_clk) disable iff (rst)
    st_r == rxcs_pkg::ST_PREAMBLE && preamble_found && !act_evt
      |=> st_r == rxcs_pkg::ST_DATA && dyn_config_sel == rxcs_pkg::DYN_DATA && detect_restart;
  endproperty
  a_pre_to_data: assert property (p_pre_to_data) else $error("preamble found, no data phase");

  property p_hold_status;
    @(posedge core_clk) disable iff (rst)
    st_r == rxcs_pkg::ST_PREAMBLE && preamble_timeout |=> held_status == $past(detect_status);
  endproperty
  a_hold_status: assert property (p_hold_status) else $error("status not held at timeout");

  property p_digit_search;
    @(posedge core_clk) disable iff (rst)
    !transparent_mode && st_r == rxcs_pkg::ST_WAKEUP ##1 !$past(transparent_mode)
      |-> pins.sclk_o && !pins.sdio_o;
  endproperty
  a_digit_search: assert property (p_digit_search) else $error("digitised search not static");

  property p_transp;
    @(posedge core_clk) disable iff (rst)
    transparent_mode |=> pins.sclk_o == $past(chip_clk) && pins.sdio_o == $past(slicer_out);
  endproperty
  a_transp: assert property (p_transp) else $error("transparent output wrong");

  property p_data_stays;
    @(posedge core_clk) disable iff (rst)
    st_r == rxcs_pkg::ST_DATA && !act_evt |=> st_r == rxcs_pkg::ST_DATA;
  endproperty
  a_data_stays: assert property (p_data_stays) else $error("data phase ended by itself");

  property p_clk_delay;
    @(posedge core_clk) disable iff (rst)
    $fell(pins.sclk_oe_n) |-> since_act_r == {1'b0, dly_at_act_r} + 6'h03;
  endproperty
  a_clk_delay: assert property (p_clk_delay) else $error("clock line delay wrong");

  property p_gain_low;
    @(posedge core_clk) disable iff (rst)
    act_evt && cmd.subcmd != rxcs_pkg::SUB_RESUME && cmd.gain_sel == rxcs_pkg::GAIN_LOW
      |=> !gain_high_sel;
  endproperty
  a_gain_low: assert property (p_gain_low) else $error("forced low gain not applied");

  property p_auto_drop;
    @(posedge core_clk) disable iff (rst)
    st_r == rxcs_pkg::ST_WAKEUP && auto_gain_r && !act_evt
      && rssi_level > high_gain_rssi_threshold |=> !gain_high_sel && st_r == $past(st_nxt);
  endproperty
  a_auto_drop: assert property (p_auto_drop) else $error("auto gain did not drop");

  property p_first_cal;
    @(posedge core_clk) disable iff (rst)
    freq_evt && !first_done_r |=> vco_cal_start && osc_start
      && device_operating_state == rxcs_pkg::DEV_STATE_RX;
  endproperty
  a_first_cal: assert property (p_first_cal) else $error("first command not calibrated");

  property p_resume_keeps;
    @(posedge core_clk) disable iff (rst)
    act_evt && cmd.subcmd == rxcs_pkg::SUB_RESUME && !wakeup_found && !wakeup_not_found
      && !preamble_found && !preamble_timeout && !poll_timer_start
      |=> $stable(st_r) ##1 !pins.sdio_oe_n;
  endproperty
  a_resume_keeps: assert property (p_resume_keeps) else $error("resume disturbed phase");

endmodule : rxcs_top

`default_nettype wire

// file: verif/rxcs_host.sv
// Host model that sends receive commands over the three-wire link
`timescale 1ns/100ps
`default_nettype none
module rxcs_host (
  output logic link_clk,
  output logic link_en_n,
  output logic link_din
);
  initial begin
    link_clk = 1'b0;
    link_en_n = 1'b1;
    link_din = 1'b1;
  end

  // Link clock stands still between frames; data is inverted once released
  task automatic send(input logic [7:0] c, input int nrise, input int gap);
    for (int i = 0; i < nrise; i++) begin
      link_en_n = 1'b0;
      link_din = (i < 8) ? c[7-i] : ~link_din;
      #24 link_clk = 1'b1;
      #24 link_clk = 1'b0;
      if (i == 7) #(gap);
    end
    #24 link_en_n = 1'b1;
    link_din = ~link_din;
  endtask : send
endmodule : rxcs_host
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench of the receive-command sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  wire logic link_clk, link_en_n, link_din;
  rxcs_pkg::rxcs_pins_s pins;
  rxcs_pkg::rxcs_state_e phase;
  logic tmode, pcf, poll, wf, wnf, pf, pto, chip_clk, slicer_out, data_clk, data_bit;
  logic osc, cal, drs, sli, sch, ghi, wrun, pev, pdr;
  logic [4:0] dly;
  logic [7:0] thr, rssi, dstat, held;
  logic [1:0] dev, dsel, wtf, wcs;
  int bad_count = 0;
  int tests_run = 0;
  int n_osc = 0, n_cal = 0, n_pev = 0, n_pdr = 0, n_sli = 0, n_drs = 0;
  int d;

  always #2 core_clk = ~core_clk;

  rxcs_host h (.link_clk(link_clk), .link_en_n(link_en_n), .link_din(link_din));

  rxcs_top uut (.core_clk(core_clk), .rst(rst), .link_clk(link_clk), .link_en_n(link_en_n),
    .link_din(link_din), .pins(pins), .transparent_mode(tmode),
    .clock_line_output_delay(dly), .after_wakeup_action_ts(2'h0),
    .after_wakeup_action_tf(wtf), .after_wakeup_action_cs(wcs),
    .after_wakeup_action_cf(2'h0), .after_preamble_action_tf(1'b0),
    .after_preamble_action_cf(pcf), .high_gain_rssi_threshold(thr), .rssi_level(rssi),
    .poll_timer_start(poll), .wakeup_found(wf), .wakeup_not_found(wnf),
    .preamble_found(pf), .preamble_timeout(pto), .detect_status(dstat),
    .chip_clk(chip_clk), .slicer_out(slicer_out), .data_clk(data_clk), .data_bit(data_bit),
    .device_operating_state(dev), .osc_start(osc), .vco_cal_start(cal), .phase(phase),
    .dyn_config_sel(dsel), .detect_restart(drs), .slicer_init(sli),
    .slicer_init_choice(sch), .held_status(held), .gain_high_sel(ghi),
    .wakeup_timer_run(wrun), .phase_end_event(pev), .power_down_req(pdr));

  // Pulses last one cycle, so they are tallied rather than sampled
  always @(negedge core_clk) begin
    if (osc === 1'b1) n_osc++;
    if (cal === 1'b1) n_cal++;
    if (pev === 1'b1) n_pev++;
    if (pdr === 1'b1) n_pdr++;
    if (sli === 1'b1) n_sli++;
    if (drs === 1'b1) n_drs++;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  // Full command; d is the lag from data-line switch to clock-line switch
  task automatic cmd(input logic [7:0] c);
    fork
      h.send(c, 9, 40);
      begin : meas
        int k;
        k = 0;
        while (pins.sdio_oe_n !== 1'b1 && k < 300) begin cyc(1); k++; end
        while (pins.sdio_oe_n !== 1'b0 && k < 300) begin cyc(1); k++; end
        d = 0;
        while (pins.sclk_oe_n !== 1'b0 && d < 40) begin cyc(1); d++; end
      end
    join
    cyc(4);
  endtask : cmd

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(3);
  endtask : pulse

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results

  initial begin
    #200000;
    bad_count++;
    $display("ERROR t=%0t watchdog expired", $time);
    results();
  end

  initial begin
    {tmode, pcf, poll, wf, wnf, pf, pto, chip_clk, slicer_out, data_clk, data_bit} = '0;
    dly = 5'h05;
    thr = 8'h80;
    wtf = rxcs_pkg::FU_POWERDOWN;
    wcs = rxcs_pkg::FU_PREAMBLE_THEN_DATA_CMD;
    rssi = 8'h10;
    dstat = 8'h00;
    cyc(8);
    chk(pins, 8'h0d, "reset pins");
    chk(phase, 8'h01, "reset phase");
    chk(ghi, 8'h01, "reset gain");
    rst = 1'b0;
    cyc(3);
    h.send(8'h90, 4, 0);
    cyc(6);
    chk(dev, rxcs_pkg::DEV_STATE_RX, "rx state");
    chk(n_osc, 8'h01, "osc start");
    chk(n_cal, 8'h01, "first cal");
    chk(phase, rxcs_pkg::ST_IDLE, "no activation");
    $display("test short frame done");
    cmd(8'h9a);
    chk(d, 8'h06, "clock line delay");
    chk(phase, rxcs_pkg::ST_PREAMBLE, "preamble start");
    chk(dsel, rxcs_pkg::DYN_PREAMBLE, "preamble set");
    chk(ghi, 8'h00, "low gain");
    chk({pins.sclk_o, pins.sdio_o}, 8'h03, "static output");
    chk(n_cal, 8'h01, "same freq");
    chk(sch, 8'h01, "slicer choice");
    dstat = 8'h5a;
    pulse(pf);
    dstat = 8'h00;
    chk(phase, rxcs_pkg::ST_DATA, "seamless data");
    chk(dsel, rxcs_pkg::DYN_DATA, "data set");
    chk(n_drs, 8'h02, "detect restart");
    chk(held, 8'h5a, "held status");
    data_clk = 1'b1;
    cyc(3);
    chk({pins.sclk_o, pins.sdio_o}, 8'h02, "data clock");
    {data_clk, data_bit} = 2'b01;
    cyc(3);
    chk({pins.sclk_o, pins.sdio_o}, 8'h01, "data bit");
    cyc(200);
    chk(phase, rxcs_pkg::ST_DATA, "data persists");
    $display("test preamble then data done");
    dly = 5'h14;
    cmd(8'haf);
    chk(d, 8'h10, "delay clamp");
    chk(phase, rxcs_pkg::ST_DATA, "direct data");
    chk(n_sli, 8'h02, "slicer init");
    chk(n_cal, 8'h02, "freq change cal");
    chk(ghi, 8'h01, "high gain");
    $display("test direct data done");
    dly = 5'h00;
    cmd(8'ha5);
    chk(d, 8'h01, "minimum delay");
    chk(phase, rxcs_pkg::ST_WAKEUP, "wakeup start");
    chk({ghi, wrun, sch}, 8'h06, "auto gain start");
    chk({pins.sclk_o, pins.sdio_o}, 8'h02, "wakeup output");
    rssi = 8'h90;
    cyc(3);
    chk({ghi, wrun}, 8'h01, "gain drop, timer on");
    rssi = 8'h10;
    cyc(3);
    chk(ghi, 8'h00, "gain stays low");
    cmd(8'ha0);
    chk(phase, rxcs_pkg::ST_WAKEUP, "resume keeps phase");
    tmode = 1'b1;
    chip_clk = 1'b1;
    cyc(3);
    chk({pins.sclk_o, pins.sdio_o}, 8'h02, "transparent clock");
    {chip_clk, slicer_out} = 2'b01;
    cyc(3);
    chk({pins.sclk_o, pins.sdio_o}, 8'h01, "transparent data");
    tmode = 1'b0;
    dstat = 8'h77;
    pulse(wf);
    chk(phase, rxcs_pkg::ST_PREAMBLE, "wakeup follow-up");
    chk(held, 8'h77, "wakeup status");
    $display("test wakeup done");
    pcf = 1'b1;
    cmd(8'ha9);
    chk(ghi, 8'h00, "gain kept");
    dstat = 8'h3c;
    pulse(pto);
    chk({dev, phase}, 8'h01, "power down");
    chk(n_pdr, 8'h01, "power down pulse");
    chk(held, 8'h3c, "timeout status");
    chk(n_pev, 8'h03, "phase end events");
    pulse(poll);
    chk({phase, wrun}, 8'h05, "timer wakeup");
    pulse(wnf);
    chk(phase, rxcs_pkg::ST_IDLE, "timer fail");
    chk(n_pdr, 8'h02, "timer power down");
    h.send(8'hec, 9, 0);
    cyc(10);
    chk(phase, rxcs_pkg::ST_IDLE, "bad header");
    chk(n_osc, 8'h06, "bad header freq");
    $display("test timeout and header done");
    results();
  end
endmodule : tb_top
`default_nettype wire
